// ===== verilog/acc_unit_pkg.sv
package acc_unit_pkg;

  // ********************************
  // instruction codes
  // ********************************
  localparam logic [7:0] INSTR_READ_PORT = 8'h0F;
  localparam logic [7:0] INSTR_CALCULATE_CMD = 8'h13;
  localparam logic [7:0] INSTR_COMPARE = 8'h14;
  localparam logic [7:0] INSTR_COND_JUMP = 8'h15;

  // ********************************
  // reply and bank codes
  // ********************************
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] BANK_OUTPUTS = 8'h02;

  // ********************************
  // calculate operation types
  // ********************************
  localparam logic [7:0] OP_ADD = 8'h00;
  localparam logic [7:0] OP_SUBTRACT = 8'h01;
  localparam logic [7:0] OP_MULTIPLY = 8'h02;
  localparam logic [7:0] OP_DIVIDE = 8'h03;
  localparam logic [7:0] OP_MODULO = 8'h04;
  localparam logic [7:0] OP_AND = 8'h05;
  localparam logic [7:0] OP_OR = 8'h06;
  localparam logic [7:0] OP_XOR = 8'h07;
  localparam logic [7:0] OP_INVERT = 8'h08;
  localparam logic [7:0] OP_LOAD = 8'h09;

  // ********************************
  // jump condition types
  // ********************************
  localparam logic [7:0] COND_ZERO = 8'h00;
  localparam logic [7:0] COND_NOT_ZERO = 8'h01;
  localparam logic [7:0] COND_EQUAL = 8'h02;
  localparam logic [7:0] COND_NOT_EQUAL = 8'h03;
  localparam logic [7:0] COND_GREATER = 8'h04;
  localparam logic [7:0] COND_GREATER_EQUAL = 8'h05;
  localparam logic [7:0] COND_LOWER = 8'h06;
  localparam logic [7:0] COND_LOWER_EQUAL = 8'h07;
  localparam logic [7:0] COND_TIMEOUT = 8'h08;
  localparam logic [7:0] COND_ALARM = 8'h09;
  localparam logic [7:0] COND_DEVIATION = 8'h0A;
  localparam logic [7:0] COND_POSITION = 8'h0B;

  // ********************************
  // reset values
  // ********************************
  localparam logic [31:0] ACC_RESET = 32'h00000000;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // ********************************
  // carriers
  // ********************************
  typedef struct packed {
    logic [7:0] instr;
    logic [7:0] op_type;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_t;

  typedef struct packed {
    logic eq;
    logic gt;
    logic lt;
  } cmp_flags_t;

  typedef struct packed {
    logic timeout_error_flag;
    logic external_alarm_flag;
    logic deviation_error_flag;
    logic position_error_flag;
  } err_flags_t;

  function automatic logic cond_met(input logic [7:0] c, input cmp_flags_t f,
                                    input err_flags_t e);
    case (c)
      COND_ZERO: cond_met = f.eq;
      COND_NOT_ZERO: cond_met = !f.eq;
      COND_EQUAL: cond_met = f.eq;
      COND_NOT_EQUAL: cond_met = !f.eq;
      COND_GREATER: cond_met = f.gt;
      COND_GREATER_EQUAL: cond_met = f.gt || f.eq;
      COND_LOWER: cond_met = f.lt;
      COND_LOWER_EQUAL: cond_met = f.lt || f.eq;
      COND_TIMEOUT: cond_met = e.timeout_error_flag;
      COND_ALARM: cond_met = e.external_alarm_flag;
      COND_DEVIATION: cond_met = e.deviation_error_flag;
      COND_POSITION: cond_met = e.position_error_flag;
      default: cond_met = 1'b0;
    endcase
  endfunction : cond_met

endpackage : acc_unit_pkg

// ===== verilog/acc_calculate_cmd_alu.sv
`timescale 1ns/10ps
module acc_calculate_cmd_alu
  import acc_unit_pkg::*;
(
  // ********************************
  // operands
  // ********************************
  input wire logic [31:0] acc_i,
  input wire logic [31:0] operand_i,
  input wire logic [7:0] op_type_i,
  // ********************************
  // result
  // ********************************
  output logic [31:0] result_o,
  output logic ok_o
);

  logic signed [31:0] a_s;
  logic signed [31:0] b_s;
  logic signed [63:0] prod_s;

  assign a_s = $signed(acc_i);
  assign b_s = $signed(operand_i);
  assign prod_s = a_s * b_s;

  always_comb begin
    result_o = acc_i;
    ok_o = 1'b1;
    case (op_type_i)
      OP_ADD: result_o = 32'(acc_i + operand_i);
      OP_SUBTRACT: result_o = 32'(acc_i - operand_i);
      OP_MULTIPLY: result_o = prod_s[31:0];
      OP_DIVIDE: begin
        // a zero divisor keeps the accumulator rather than invent a value
        ok_o = (operand_i != 32'h00000000);
        if (ok_o) begin
          result_o = 32'(a_s / b_s);
        end
      end
      OP_MODULO: begin
        ok_o = (operand_i != 32'h00000000);
        if (ok_o) begin
          result_o = 32'(a_s % b_s);
        end
      end
      OP_AND: result_o = acc_i & operand_i;
      OP_OR: result_o = acc_i | operand_i;
      OP_XOR: result_o = acc_i ^ operand_i;
      OP_INVERT: result_o = ~acc_i;
      OP_LOAD: result_o = operand_i;
      default: ok_o = 1'b0;
    endcase
  end

endmodule : acc_calculate_cmd_alu

// ===== verilog/accumulator_compare_branch_unit.sv
`timescale 1ns/10ps
module accumulator_compare_branch_unit
  import acc_unit_pkg::*;
#(
  parameter int PC_W = 32,
  parameter int DOUT_W = 2
) (
  // ********************************
  // clock, reset, enable
  // ********************************
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  // ********************************
  // command
  // ********************************
  input wire logic cmd_valid_i,
  input wire cmd_t cmd_i,
  input wire logic standalone_i,
  // ********************************
  // surrounding controller state
  // ********************************
  input wire logic [DOUT_W-1:0] out_state_i,
  input wire err_flags_t err_flags_i,
  // ********************************
  // results
  // ********************************
  output logic [31:0] acc_o,
  output logic [PC_W-1:0] pc_o,
  output cmp_flags_t cmp_flags_o,
  output logic jump_taken_o,
  // ********************************
  // direct-mode reply
  // ********************************
  output logic reply_valid_o,
  output logic [7:0] reply_status_o,
  output logic [31:0] reply_value_o
);

  typedef struct packed {
    logic [31:0] acc;
    logic [PC_W-1:0] pc;
    cmp_flags_t flags;
    logic jump;
    logic rvalid;
    logic [7:0] rstatus;
    logic [31:0] rvalue;
  } state_t;

  state_t q;
  state_t d;
  logic [31:0] alu_res;
  logic alu_ok;
  logic [DOUT_W-1:0] out_shift;
  logic port_ok;
  logic [31:0] port_val;
  logic taken;

  acc_calculate_cmd_alu u_alu (
    .acc_i(q.acc),
    .operand_i(cmd_i.value),
    .op_type_i(cmd_i.op_type),
    .result_o(alu_res),
    .ok_o(alu_ok)
  );

  // ********************************
  // output bank readback
  // ********************************
  assign out_shift = out_state_i >> cmd_i.op_type;
  assign port_ok = (cmd_i.bank == BANK_OUTPUTS) && (32'(cmd_i.op_type) < DOUT_W);
  assign port_val = {31'h00000000, out_shift[0]};
  // compare conditions look at the flags of the last compare, not this cycle's command
  assign taken = cond_met(cmd_i.op_type, q.flags, err_flags_i);

  // ********************************
  // next state
  // ********************************
  always_comb begin
    d = q;
    d.jump = 1'b0;
    d.rvalid = 1'b0;
    if (cmd_valid_i) begin
      case (cmd_i.instr)
        INSTR_CALCULATE_CMD: begin
          if (alu_ok) begin
            d.acc = alu_res;
          end
          d.rvalid = !standalone_i;
          d.rstatus = STATUS_OK;
          d.rvalue = cmd_i.value;
          if (standalone_i) begin
            d.pc = q.pc + 1'b1;
          end
        end
        INSTR_COMPARE: begin
          d.flags.eq = (q.acc == cmd_i.value);
          d.flags.gt = ($signed(q.acc) > $signed(cmd_i.value));
          d.flags.lt = ($signed(q.acc) < $signed(cmd_i.value));
          d.rvalid = !standalone_i;
          d.rstatus = STATUS_OK;
          d.rvalue = 32'h00000000;
          if (standalone_i) begin
            d.pc = q.pc + 1'b1;
          end
        end
        INSTR_COND_JUMP: begin
          d.rvalid = !standalone_i;
          d.rstatus = STATUS_OK;
          d.rvalue = 32'h00000000;
          if (taken) begin
            d.pc = cmd_i.value[PC_W-1:0];
            d.jump = 1'b1;
          end else if (standalone_i) begin
            d.pc = q.pc + 1'b1;
          end
        end
        INSTR_READ_PORT: begin
          // only the output bank lives here; other banks are left to their owners
          if (port_ok) begin
            if (standalone_i) begin
              d.acc = port_val;
              d.pc = q.pc + 1'b1;
            end
            d.rvalid = !standalone_i;
            d.rstatus = STATUS_OK;
            d.rvalue = port_val;
          end
        end
        default: begin
          d.rvalid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      q <= '{acc: ACC_RESET, rstatus: STATUS_RESET, default: '0};
    end else if (en_i) begin
      q <= d;
    end
  end

  assign acc_o = q.acc;
  assign pc_o = q.pc;
  assign cmp_flags_o = q.flags;
  assign jump_taken_o = q.jump;
  assign reply_valid_o = q.rvalid;
  assign reply_status_o = q.rstatus;
  assign reply_value_o = q.rvalue;

  // ********************************
  // checks
  // ********************************
  AST_CALCULATE_CMD_ADD: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_CALCULATE_CMD && cmd_i.op_type == OP_ADD
    |=> acc_o == 32'($past(acc_o) + $past(cmd_i.value)))
    else $error("add result wrong");

  AST_CALCULATE_CMD_INVERT: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_CALCULATE_CMD && cmd_i.op_type == OP_INVERT
    |=> acc_o == ~$past(acc_o))
    else $error("invert result wrong");

  AST_CALCULATE_CMD_LOAD: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_CALCULATE_CMD && cmd_i.op_type == OP_LOAD
    |=> acc_o == $past(cmd_i.value))
    else $error("load result wrong");

  AST_CALCULATE_CMD_REPLY: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_CALCULATE_CMD && !standalone_i
    |=> reply_valid_o && reply_status_o == STATUS_OK && reply_value_o == $past(cmd_i.value))
    else $error("calculate reply wrong");

  AST_COMPARE_FLAGS: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_COMPARE
    |=> $stable(acc_o) && cmp_flags_o.eq == ($past(acc_o) == $past(cmd_i.value))
        && cmp_flags_o.gt == ($signed($past(acc_o)) > $signed($past(cmd_i.value)))
        && cmp_flags_o.lt == ($signed($past(acc_o)) < $signed($past(cmd_i.value))))
    else $error("compare flags wrong");

  AST_JUMP_TAKEN: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_COND_JUMP && taken
    |=> jump_taken_o && pc_o == $past(cmd_i.value[PC_W-1:0]))
    else $error("jump not taken");

  AST_JUMP_SKIP: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_COND_JUMP && !taken && standalone_i
    |=> !jump_taken_o && pc_o == PC_W'($past(pc_o) + 1'b1) && $stable(acc_o)
        && $stable(cmp_flags_o))
    else $error("unmet jump wrong");

  AST_READ_STANDALONE: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_READ_PORT && port_ok && standalone_i
    |=> acc_o == {31'h00000000, $past(out_shift[0])} && !reply_valid_o)
    else $error("standalone read wrong");

  AST_READ_DIRECT: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_READ_PORT && port_ok && !standalone_i
    |=> $stable(acc_o) && reply_valid_o && reply_value_o == $past(port_val))
    else $error("direct read wrong");

  AST_JUMP_GE: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_COND_JUMP && cmd_i.op_type == COND_GREATER_EQUAL
    |=> jump_taken_o == ($past(cmp_flags_o.gt) || $past(cmp_flags_o.eq)))
    else $error("greater or equal jump wrong");

  AST_JUMP_ALARM: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    en_i && cmd_valid_i && cmd_i.instr == INSTR_COND_JUMP && cmd_i.op_type == COND_ALARM
    |=> jump_taken_o == $past(err_flags_i.external_alarm_flag))
    else $error("alarm jump wrong");

endmodule : accumulator_compare_branch_unit

// ===== sim/cmd_host.sv
`timescale 1ns/10ps
module cmd_host
  import acc_unit_pkg::*;
(
  // ********************************
  // request from the bench
  // ********************************
  input wire logic valid_i,
  input wire logic standalone_i,
  input wire logic [7:0] instr_i,
  input wire logic [7:0] type_i,
  input wire logic [7:0] bank_i,
  input wire logic [3:0][7:0] bytes_i,
  // ********************************
  // command toward the unit
  // ********************************
  output logic valid_o,
  output logic standalone_o,
  output cmd_t cmd_o
);
  assign valid_o = valid_i;
  // compare is forced into program mode, never sent as a direct command
  assign standalone_o = standalone_i | (instr_i == INSTR_COMPARE);
  // byte 3 travels first and lands in the top of the value word
  assign cmd_o.instr = instr_i;
  assign cmd_o.op_type = type_i;
  assign cmd_o.bank = bank_i;
  assign cmd_o.value = {bytes_i[3], bytes_i[2], bytes_i[1], bytes_i[0]};
endmodule : cmd_host

// ===== sim/tb_accumulator_compare_branch_unit.sv
`timescale 1ns/10ps
module tb_accumulator_compare_branch_unit;
  import acc_unit_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic en_i = 1'b0;
  logic h_valid = 1'b0;
  logic h_sa = 1'b0;
  logic [7:0] h_instr = 8'h00;
  logic [7:0] h_type = 8'h00;
  logic [7:0] h_bank = 8'h00;
  logic [3:0][7:0] h_bytes = 32'h00000000;
  logic [1:0] out_state_i = 2'h0;
  err_flags_t err_flags_i = 4'h0;
  logic cmd_valid_i, standalone_i, jump_taken_o, reply_valid_o;
  cmd_t cmd_i;
  cmp_flags_t cmp_flags_o;
  logic [31:0] acc_o, pc_o, reply_value_o, m_pc, m_rval;
  logic [7:0] reply_status_o, m_rstat;
  logic signed [31:0] m_acc, m_v;
  logic m_eq, m_gt, m_lt, m_rv, m_jt, cond;
  logic [7:0] instrs [5] = '{INSTR_READ_PORT, INSTR_CALCULATE_CMD, INSTR_COMPARE, INSTR_COND_JUMP, 8'h0E};
  int seed = 16885;
  int miscompares = 0;
  int num_checks = 0;
  int i;

  always #10 ref_clk_i = ~ref_clk_i;

  cmd_host host (.valid_i(h_valid), .standalone_i(h_sa), .instr_i(h_instr), .type_i(h_type),
    .bank_i(h_bank), .bytes_i(h_bytes), .valid_o(cmd_valid_i), .standalone_o(standalone_i),
    .cmd_o(cmd_i));

  accumulator_compare_branch_unit uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .en_i(en_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .standalone_i(standalone_i),
    .out_state_i(out_state_i), .err_flags_i(err_flags_i), .acc_o(acc_o), .pc_o(pc_o),
    .cmp_flags_o(cmp_flags_o), .jump_taken_o(jump_taken_o), .reply_valid_o(reply_valid_o),
    .reply_status_o(reply_status_o), .reply_value_o(reply_value_o));

  // ********************************
  // checking
  // ********************************
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task finish_test;
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  // ********************************
  // reference model
  // ********************************
  task reply(input logic [31:0] v);
    // status and value latch in both modes; only the strobe marks a real reply
    m_rv = !standalone_i;
    m_rstat = 8'h64;
    m_rval = v;
  endtask : reply

  task model;
    m_v = {h_bytes[3], h_bytes[2], h_bytes[1], h_bytes[0]};
    // reset wins over the enable, as in the unit
    if (!rst_n_i) begin
      {m_acc, m_pc, m_rval, m_rstat, m_eq, m_gt, m_lt, m_rv, m_jt} = '0;
    // a frozen unit keeps every output, pulses included
    end else if (en_i) begin
      m_rv = 1'b0;
      m_jt = 1'b0;
      if (cmd_valid_i) begin
        case (h_instr)
          8'h13: begin
            case (h_type)
              8'h00: m_acc = m_acc + m_v;
              8'h01: m_acc = m_acc - m_v;
              8'h02: m_acc = m_acc * m_v;
              8'h03: if (m_v != 0) m_acc = m_acc / m_v;
              8'h04: if (m_v != 0) m_acc = m_acc % m_v;
              8'h05: m_acc = m_acc & m_v;
              8'h06: m_acc = m_acc | m_v;
              8'h07: m_acc = m_acc ^ m_v;
              8'h08: m_acc = ~m_acc;
              8'h09: m_acc = m_v;
              default: ;
            endcase
            reply(m_v);
            if (standalone_i) m_pc++;
          end
          8'h14: begin
            m_eq = (m_acc == m_v);
            m_gt = (m_acc > m_v);
            m_lt = (m_acc < m_v);
            reply(32'h00000000);
            if (standalone_i) m_pc++;
          end
          8'h15: begin
            case (h_type)
              8'h00, 8'h02: cond = m_eq;
              8'h01, 8'h03: cond = !m_eq;
              8'h04: cond = m_gt;
              8'h05: cond = m_gt | m_eq;
              8'h06: cond = m_lt;
              8'h07: cond = m_lt | m_eq;
              8'h08: cond = err_flags_i.timeout_error_flag;
              8'h09: cond = err_flags_i.external_alarm_flag;
              8'h0A: cond = err_flags_i.deviation_error_flag;
              8'h0B: cond = err_flags_i.position_error_flag;
              default: cond = 1'b0;
            endcase
            m_jt = cond;
            if (cond) m_pc = m_v;
            else if (standalone_i) m_pc++;
            reply(32'h00000000);
          end
          8'h0F: begin
            if (h_bank == 8'h02 && h_type < 2) begin
              if (standalone_i) m_acc = {31'h0, out_state_i[h_type[0]]};
              reply({31'h0, out_state_i[h_type[0]]});
              if (standalone_i) m_pc++;
            end
          end
          default: ;
        endcase
      end
    end
  endtask : model

  // ********************************
  // main sequence
  // ********************************
  initial begin
    {m_acc, m_pc, m_rval, m_rstat, m_eq, m_gt, m_lt, m_rv, m_jt} = '0;
    repeat (5) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    // random commands, valid in about three cycles of four, each checked one cycle later
    for (i = 0; i < 600; i++) begin
      @(negedge ref_clk_i);
      chk("acc", m_acc, acc_o);
      chk("pc", m_pc, pc_o);
      chk("flags", {29'h0, m_eq, m_gt, m_lt}, {29'h0, cmp_flags_o});
      chk("jump", {31'h0, m_jt}, {31'h0, jump_taken_o});
      chk("rvalid", {31'h0, m_rv}, {31'h0, reply_valid_o});
      chk("rstatus", {24'h0, m_rstat}, {24'h0, reply_status_o});
      chk("rvalue", m_rval, reply_value_o);
      en_i = ($random(seed) & 7) != 0;
      h_valid = ($random(seed) & 3) != 0;
      h_sa = $random(seed);
      h_instr = instrs[$unsigned($random(seed)) % 5];
      h_type = $unsigned($random(seed)) % 13;
      h_bank = $unsigned($random(seed)) % 4;
      // reads mostly aim at the two output ports so their checks are reached
      if (h_instr == INSTR_READ_PORT && ($random(seed) & 1)) begin
        h_bank = BANK_OUTPUTS;
        h_type = $random(seed) & 1;
      end
      // equal operands make compares and equality jumps meet often
      if (($random(seed) & 3) == 0) h_bytes = m_acc;
      else if ($random(seed) & 1) h_bytes = $random(seed) % 64;
      else h_bytes = $random(seed);
      out_state_i = $random(seed);
      err_flags_i = $random(seed);
      // one reset in mid-run must bring every register back to its reset value
      rst_n_i = (i != 300);
      #1;
      model;
    end
    finish_test;
  end
endmodule : tb_accumulator_compare_branch_unit
